//--- hw/protect_if.sv
// Carrier between the clock core and the write-protect unit
`default_nettype none

interface protect_if;
	logic wrEn;
	logic [3:0] wrSel;
	logic [7:0] wrData;
	logic clockEn;
	logic powerEn;
	logic oneshotEn;
	logic [7:0] protectQ;

	modport unit (
		input wrEn, wrSel, wrData,
		output clockEn, powerEn, oneshotEn, protectQ
	);
	modport core (
		output wrEn, wrSel, wrData,
		input clockEn, powerEn, oneshotEn, protectQ
	);
endinterface

`default_nettype wire

//--- hw/stop_clock_pkg.sv
// Constants and types for stop-mode clock control and write protection
`default_nettype none

package stop_clock_pkg;

	// ----------------------------------------------------------------
	// Register selects
	// ----------------------------------------------------------------
	localparam logic [3:0] SEL_CLOCK_CONTROL0 = 4'h0;
	localparam logic [3:0] SEL_CLOCK_CONTROL1 = 4'h1;
	localparam logic [3:0] SEL_PERIPHERAL_CLOCK = 4'h2;
	localparam logic [3:0] SEL_POWER_MODE0 = 4'h3;
	localparam logic [3:0] SEL_POWER_MODE1 = 4'h4;
	localparam logic [3:0] SEL_POWER_MODE2 = 4'h5;
	localparam logic [3:0] SEL_WRITE_PROTECT = 4'h6;
	localparam logic [3:0] SEL_PORT_DIRECTION = 4'h7;
	localparam logic [3:0] SEL_SERIAL_A_CONTROL = 4'h8;
	localparam logic [3:0] SEL_SERIAL_B_CONTROL = 4'h9;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int WAIT_PERIPH_CLOCK_STOP_BIT = 2;
	localparam int MAIN_OSC_HALT_BIT = 5;
	localparam int CPU_DIV8_SELECT_BIT = 6;
	localparam int CPU_CLOCK_SOURCE_BIT = 7;
	localparam int STOP_ALL_CLOCKS_BIT = 0;
	localparam int SUB_CLOCK_ONLY_BIT = 1;
	localparam int MAIN_OSC_HIGH_DRIVE_BIT = 5;
	localparam int CLOCK_CHANGE_LOCK_BIT = 1;
	localparam int CLOCK_REGS_WRITE_ENABLE = 0;
	localparam int POWER_REGS_WRITE_ENABLE = 1;
	localparam int ONESHOT_PORT_SERIAL_WRITE_ENABLE = 2;
	localparam logic [7:0] CLOCK_CONTROL0_LOCK_MASK = 8'hA4;
	localparam logic [7:0] CLOCK_CONTROL1_LOCK_MASK = 8'h03;
	localparam logic [7:0] WRITE_PROTECT_MASK = 8'h07;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CLOCK_CONTROL0_RESET = 8'h00;
	localparam logic [7:0] CLOCK_CONTROL1_RESET = 8'h00;
	localparam logic [7:0] GENERIC_REG_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Counts and selections
	// ----------------------------------------------------------------
	localparam int WAKE_SOURCES = 5;
	localparam logic [2:0] DIV8_LAST = 3'h7;
	localparam logic [1:0] CLOCK_OUTPUT_PIN_PORT = 2'h0;
	localparam logic [1:0] CLOCK_OUTPUT_PIN_SUB_DERIVED = 2'h1;
	localparam logic [1:0] CLOCK_OUTPUT_PIN_DIV8 = 2'h2;
	localparam logic [1:0] CLOCK_OUTPUT_PIN_DIV32 = 2'h3;

	typedef enum logic [2:0] {
		ST_RUN = 3'h1,
		ST_STOP = 3'h2,
		ST_WAKE = 3'h4
	} clk_state_t;

endpackage

`default_nettype wire

//--- hw/stop_mode_clock_protect.sv
// Stop-mode clock control, clock-change lock and protected registers
`default_nettype none

module stop_mode_clock_protect
	import stop_clock_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic wrEn,
	input wire logic [3:0] wrSel,
	input wire logic [7:0] wrData,
	output logic [7:0] clockControl0,
	output logic [7:0] clockControl1,
	output logic [7:0] peripheralClock,
	output logic [7:0] powerMode0,
	output logic [7:0] powerMode1,
	output logic [7:0] powerMode2,
	output logic [7:0] writeProtect,
	output logic [7:0] portDirection,
	output logic [7:0] serialAControl,
	output logic [7:0] serialBControl,
	input wire logic nmiN,
	input wire logic [WAKE_SOURCES-1:0] wakeIrqReq,
	input wire logic [3*WAKE_SOURCES-1:0] irqPriorityLevel,
	input wire logic globalIrqEnable,
	input wire logic subTick,
	input wire logic crystalVcoEnable,
	input wire logic pageDataVcoEnable,
	input wire logic programmeDeliveryVcoEnable,
	input wire logic singleChipMode,
	input wire logic [19:0] busAddrIn,
	input wire logic [15:0] busDataIn,
	input wire logic [3:0] chipSelectInN,
	input wire logic byteHighEnableInN,
	input wire logic [7:0] ioPortIn,
	input wire logic readInN,
	input wire logic writeInN,
	input wire logic holdAckInN,
	input wire logic busClockIn,
	input wire logic latchEnableIn,
	input wire logic [1:0] clockOutSel,
	input wire logic clockOutSrc,
	output logic stopped,
	output logic mainOscRun,
	output logic subOscRun,
	output logic cpuClockRun,
	output logic cpuTick,
	output logic periphClockRun,
	output logic extPeriphRun,
	output logic expOscRun,
	output logic irqServiceStart,
	output logic wakeByNmi,
	output logic [19:0] busAddr,
	output logic [15:0] busData,
	output logic [3:0] chipSelectN,
	output logic byteHighEnableOutputN,
	output logic [7:0] ioPort,
	output logic readN,
	output logic writeN,
	output logic holdAcknowledgeOutputN,
	output logic busClock,
	output logic latchEnable,
	output logic clockOutputPin
);

	protect_if prot ();

	write_protect_unit u_protect (
		.clk(clk),
		.resetn(resetn),
		.prot(prot)
	);

	clk_state_t state_q;
	clk_state_t state_d;
	logic [7:0] cm0_q;
	logic [7:0] cm1_q;
	logic [7:0] pclk_q;
	logic [7:0] pm0_q;
	logic [7:0] pm1_q;
	logic [7:0] pm2_q;
	logic [7:0] pdir_q;
	logic [7:0] sa_q;
	logic [7:0] sb_q;
	logic [2:0] div_q;
	logic nmiPrev_q;
	logic irqStart_q;
	logic nmiWake_q;
	logic locked;
	logic running;
	logic clockWr;
	logic powerWr;
	logic oneshotWr;
	logic stopReq;
	logic nmiFall;
	logic irqWake;
	logic [7:0] cm0Next;
	logic [7:0] cm1Next;

	assign prot.wrEn = wrEn & running;
	assign prot.wrSel = wrSel;
	assign prot.wrData = wrData;

	// ----------------------------------------------------------------
	// Write qualification
	// ----------------------------------------------------------------
	assign running = (state_q == ST_RUN);
	assign locked = pm2_q[CLOCK_CHANGE_LOCK_BIT];
	assign clockWr = wrEn & running & prot.clockEn;
	assign powerWr = wrEn & running & prot.powerEn;
	assign oneshotWr = wrEn & running & prot.oneshotEn;

	// Locked bits keep their stored value
	assign cm0Next = locked ? ((cm0_q & CLOCK_CONTROL0_LOCK_MASK) |
		(wrData & ~CLOCK_CONTROL0_LOCK_MASK)) : wrData;
	assign cm1Next = locked ? ((cm1_q & CLOCK_CONTROL1_LOCK_MASK) |
		(wrData & ~CLOCK_CONTROL1_LOCK_MASK)) : wrData;
	assign stopReq = clockWr & (wrSel == SEL_CLOCK_CONTROL1) & cm1Next[STOP_ALL_CLOCKS_BIT];

	// ----------------------------------------------------------------
	// Wake detection
	// ----------------------------------------------------------------
	assign nmiFall = nmiPrev_q & ~nmiN;

	always_comb begin
		irqWake = 1'b0;
		for (int i = 0; i < WAKE_SOURCES; i++) begin
			if (wakeIrqReq[i] && (irqPriorityLevel[3*i +: 3] != 3'h0)) begin
				irqWake = globalIrqEnable;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			nmiPrev_q <= 1'b1;
		end else begin
			nmiPrev_q <= nmiN;
		end
	end

	// ----------------------------------------------------------------
	// Mode state machine
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_RUN: begin
				if (stopReq) begin
					state_d = ST_STOP;
				end
			end
			ST_STOP: begin
				if (nmiFall || irqWake) begin
					state_d = ST_WAKE;
				end
			end
			ST_WAKE: begin
				state_d = ST_RUN;
			end
			default: begin
				state_d = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q <= ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// Service start follows the clock restart by one cycle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			irqStart_q <= 1'b0;
			nmiWake_q <= 1'b0;
		end else begin
			irqStart_q <= (state_q == ST_WAKE);
			if (state_q == ST_STOP && state_d == ST_WAKE) begin
				nmiWake_q <= nmiFall;
			end
		end
	end

	// ----------------------------------------------------------------
	// Clock control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cm0_q <= CLOCK_CONTROL0_RESET;
			cm1_q <= CLOCK_CONTROL1_RESET;
			pclk_q <= GENERIC_REG_RESET;
		end else begin
			if (clockWr && wrSel == SEL_CLOCK_CONTROL0) begin
				cm0_q <= cm0Next;
			end
			if (clockWr && wrSel == SEL_PERIPHERAL_CLOCK) begin
				pclk_q <= wrData;
			end
			if (stopReq) begin
				cm1_q <= cm1Next | (8'h01 << MAIN_OSC_HIGH_DRIVE_BIT);
				cm0_q[CPU_DIV8_SELECT_BIT] <= 1'b1;
			end else if (clockWr && wrSel == SEL_CLOCK_CONTROL1) begin
				cm1_q <= cm1Next;
			end else if (state_q == ST_WAKE) begin
				cm1_q[STOP_ALL_CLOCKS_BIT] <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Power mode and one-shot protected registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pm0_q <= GENERIC_REG_RESET;
			pm1_q <= GENERIC_REG_RESET;
			pm2_q <= GENERIC_REG_RESET;
			pdir_q <= GENERIC_REG_RESET;
			sa_q <= GENERIC_REG_RESET;
			sb_q <= GENERIC_REG_RESET;
		end else begin
			if (powerWr && wrSel == SEL_POWER_MODE0) begin
				pm0_q <= wrData;
			end
			if (powerWr && wrSel == SEL_POWER_MODE1) begin
				pm1_q <= wrData;
			end
			if (powerWr && wrSel == SEL_POWER_MODE2) begin
				pm2_q <= wrData;
			end
			if (oneshotWr && wrSel == SEL_PORT_DIRECTION) begin
				pdir_q <= wrData;
			end
			if (oneshotWr && wrSel == SEL_SERIAL_A_CONTROL) begin
				sa_q <= wrData;
			end
			if (oneshotWr && wrSel == SEL_SERIAL_B_CONTROL) begin
				sb_q <= wrData;
			end
		end
	end

	// ----------------------------------------------------------------
	// Clock enables and CPU divider
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			div_q <= 3'h0;
		end else if (state_q == ST_STOP) begin
			div_q <= 3'h0;
		end else begin
			div_q <= div_q + 3'h1;
		end
	end

	assign stopped = (state_q == ST_STOP);
	assign cpuClockRun = ~stopped;
	assign periphClockRun = ~stopped;
	assign mainOscRun = ~stopped & ~cm0_q[MAIN_OSC_HALT_BIT];
	assign subOscRun = ~stopped;
	assign extPeriphRun = 1'b1;
	assign expOscRun = crystalVcoEnable | pageDataVcoEnable | programmeDeliveryVcoEnable;

	// Source bit survives stop, div8 is forced at entry
	always_comb begin
		if (stopped) begin
			cpuTick = 1'b0;
		end else if (cm0_q[CPU_CLOCK_SOURCE_BIT]) begin
			cpuTick = subTick;
		end else if (cm0_q[CPU_DIV8_SELECT_BIT]) begin
			cpuTick = (div_q == DIV8_LAST);
		end else begin
			cpuTick = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Pin states
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			busAddr <= 20'h0_0000;
			busData <= 16'h0000;
			chipSelectN <= 4'hF;
			byteHighEnableOutputN <= 1'b1;
			ioPort <= 8'h00;
			clockOutputPin <= 1'b0;
		end else if (state_d == ST_STOP) begin
			if (singleChipMode && clockOutSel == CLOCK_OUTPUT_PIN_SUB_DERIVED) begin
				clockOutputPin <= 1'b1;
			end
		end else begin
			busAddr <= busAddrIn;
			busData <= busDataIn;
			chipSelectN <= chipSelectInN;
			byteHighEnableOutputN <= byteHighEnableInN;
			ioPort <= ioPortIn;
			clockOutputPin <= (clockOutSel == CLOCK_OUTPUT_PIN_PORT) ? ioPortIn[0] : clockOutSrc;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			readN <= 1'b1;
			writeN <= 1'b1;
			holdAcknowledgeOutputN <= 1'b1;
			busClock <= 1'b1;
			latchEnable <= 1'b1;
		end else if (state_d == ST_STOP) begin
			if (!singleChipMode) begin
				readN <= 1'b1;
				writeN <= 1'b1;
				holdAcknowledgeOutputN <= 1'b1;
				busClock <= 1'b1;
				latchEnable <= 1'b1;
			end
		end else begin
			readN <= readInN;
			writeN <= writeInN;
			holdAcknowledgeOutputN <= holdAckInN;
			busClock <= busClockIn;
			latchEnable <= latchEnableIn;
		end
	end

	assign irqServiceStart = irqStart_q;
	assign wakeByNmi = nmiWake_q;
	assign clockControl0 = cm0_q;
	assign clockControl1 = cm1_q;
	assign peripheralClock = pclk_q;
	assign powerMode0 = pm0_q;
	assign powerMode1 = pm1_q;
	assign powerMode2 = pm2_q;
	assign writeProtect = prot.protectQ;
	assign portDirection = pdir_q;
	assign serialAControl = sa_q;
	assign serialBControl = sb_q;

endmodule // stop_mode_clock_protect

`default_nettype wire

//--- hw/write_protect_unit.sv
// Write-protect register with its three group enables
`default_nettype none

module write_protect_unit
	import stop_clock_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	protect_if.unit prot
);

	logic [7:0] protect_q;
	logic [7:0] protect_d;

	// ----------------------------------------------------------------
	// Register update
	// ----------------------------------------------------------------
	always_comb begin
		protect_d = protect_q;
		if (prot.wrEn) begin
			if (prot.wrSel == SEL_WRITE_PROTECT) begin
				protect_d = prot.wrData & WRITE_PROTECT_MASK;
			end else begin
				protect_d[ONESHOT_PORT_SERIAL_WRITE_ENABLE] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			protect_q <= GENERIC_REG_RESET;
		end else begin
			protect_q <= protect_d;
		end
	end

	// ----------------------------------------------------------------
	// Group enables
	// ----------------------------------------------------------------
	assign prot.clockEn = protect_q[CLOCK_REGS_WRITE_ENABLE];
	assign prot.powerEn = protect_q[POWER_REGS_WRITE_ENABLE];
	assign prot.oneshotEn = protect_q[ONESHOT_PORT_SERIAL_WRITE_ENABLE];
	assign prot.protectQ = protect_q;

endmodule // write_protect_unit

`default_nettype wire

//--- tb/stop_mode_clock_protect_checker.sv
// Assertion checker for the stop-mode clock and protect block
`default_nettype none

module stop_mode_clock_protect_checker
	import stop_clock_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic wrEn,
	input wire logic [3:0] wrSel,
	input wire logic [7:0] wrData,
	input wire logic [7:0] clockControl0,
	input wire logic [7:0] clockControl1,
	input wire logic [7:0] powerMode2,
	input wire logic [7:0] writeProtect,
	input wire logic [7:0] portDirection,
	input wire logic nmiN,
	input wire logic [WAKE_SOURCES-1:0] wakeIrqReq,
	input wire logic [3*WAKE_SOURCES-1:0] irqPriorityLevel,
	input wire logic globalIrqEnable,
	input wire logic crystalVcoEnable,
	input wire logic pageDataVcoEnable,
	input wire logic programmeDeliveryVcoEnable,
	input wire logic stopped,
	input wire logic mainOscRun,
	input wire logic subOscRun,
	input wire logic cpuClockRun,
	input wire logic cpuTick,
	input wire logic periphClockRun,
	input wire logic extPeriphRun,
	input wire logic expOscRun,
	input wire logic irqServiceStart
);
	// ----
	// Helpers
	// ----
	logic [WAKE_SOURCES-1:0] lvlOn;
	logic stopSeen_q;
	logic run;
	always_comb begin
		for (int i = 0; i < WAKE_SOURCES; i++) begin
			lvlOn[i] = |irqPriorityLevel[3*i +: 3];
		end
	end
	always_ff @(posedge clk) begin
		stopSeen_q <= resetn ? stopped : 1'b0;
	end
	assign run = !stopped && !stopSeen_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// ----
	// Properties
	// ----
	property p_stopEnter;
		run && wrEn && wrSel == SEL_CLOCK_CONTROL1 && wrData[0] && writeProtect[0] &&
			!powerMode2[1] |=> stopped && clockControl1[0] && clockControl1[5] &&
			clockControl0[6];
	endproperty
	a_stopEnter: assert property (p_stopEnter) else $error("stop entry wrong");
	property p_halt;
		stopped |-> !mainOscRun && !subOscRun && !cpuClockRun && !cpuTick && !periphClockRun;
	endproperty
	a_halt: assert property (p_halt) else $error("clock running in stop");
	property p_extRun;
		stopped |-> extPeriphRun;
	endproperty
	a_extRun: assert property (p_extRun) else $error("external peripherals halted");
	property p_nmiWake;
		stopped && $past(nmiN) && !nmiN |=> !stopped && cpuClockRun ##1 irqServiceStart;
	endproperty
	a_nmiWake: assert property (p_nmiWake) else $error("no wake on nmi");
	property p_irqWake;
		stopped && globalIrqEnable && |(wakeIrqReq & lvlOn) |=>
			!stopped ##1 irqServiceStart ##1 !irqServiceStart;
	endproperty
	a_irqWake: assert property (p_irqWake) else $error("no wake on irq");
	property p_noWake;
		stopped && !($past(nmiN) && !nmiN) && !(globalIrqEnable && |(wakeIrqReq & lvlOn))
			|=> stopped;
	endproperty
	a_noWake: assert property (p_noWake) else $error("wake without source");
	property p_lock;
		powerMode2[1] |=> (clockControl0 & CLOCK_CONTROL0_LOCK_MASK) ==
			($past(clockControl0) & CLOCK_CONTROL0_LOCK_MASK) &&
			clockControl1[1:0] == $past(clockControl1[1:0]);
	endproperty
	a_lock: assert property (p_lock) else $error("locked bit changed");
	property p_prot2Clear;
		run && wrEn && wrSel != SEL_WRITE_PROTECT |=> !writeProtect[2];
	endproperty
	a_prot2Clear: assert property (p_prot2Clear) else $error("protect bit 2 kept");
	property p_prot01Keep;
		!(wrEn && wrSel == SEL_WRITE_PROTECT) |=> $stable(writeProtect[1:0]);
	endproperty
	a_prot01Keep: assert property (p_prot01Keep) else $error("protect bits moved");
	property p_refuse;
		wrEn && wrSel == SEL_PORT_DIRECTION && !writeProtect[2] |=> $stable(portDirection);
	endproperty
	a_refuse: assert property (p_refuse) else $error("refused write landed");
	property p_expOsc;
		expOscRun == (crystalVcoEnable || pageDataVcoEnable || programmeDeliveryVcoEnable);
	endproperty
	a_expOsc: assert property (p_expOsc) else $error("expansion oscillator wrong");
endmodule // stop_mode_clock_protect_checker

bind stop_mode_clock_protect stop_mode_clock_protect_checker checker_i (.*);

`default_nettype wire

//--- tb/tb_stop_mode_clock_protect.sv
// Self-checking bench for the stop-mode clock and protect block
`default_nettype none

module tb_stop_mode_clock_protect
	import stop_clock_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 0, resetn = 0, wrEn = 0, nmiN = 1, globalIrqEnable = 0, subTick = 0;
	logic singleChipMode = 1;
	logic [1:0] clockOutSel = 2'h0;
	logic [3:0] wrSel = 4'h0;
	logic [7:0] wrData = 8'h00;
	logic [WAKE_SOURCES-1:0] wakeIrqReq = '0;
	logic [3*WAKE_SOURCES-1:0] irqPriorityLevel = '0;
	logic [63:0] rnd = '0;
	logic [7:0] clockControl0, clockControl1, peripheralClock, powerMode0, powerMode1;
	logic [7:0] powerMode2, writeProtect, portDirection, serialAControl, serialBControl;
	logic stopped, mainOscRun, subOscRun, cpuClockRun, cpuTick, periphClockRun;
	logic extPeriphRun, expOscRun, irqServiceStart, wakeByNmi, clockOutputPin;
	logic byteHighEnableOutputN, readN, writeN, holdAcknowledgeOutputN, busClock, latchEnable;
	logic [19:0] busAddr;
	logic [15:0] busData;
	logic [3:0] chipSelectN;
	logic [7:0] ioPort;
	logic [7:0] regs [10];
	int m [10];
	int mp, err_count = 0, samples_checked = 0, cycles = 0, seed = 32'h0000_e9f0;
	int i, k, s, d, n, t, a, p, c;

	stop_mode_clock_protect stop_mode_clock_protect_i (.*, .busAddrIn(rnd[19:0]),
		.busDataIn(rnd[35:20]), .chipSelectInN(rnd[39:36]), .byteHighEnableInN(rnd[40]),
		.ioPortIn(rnd[48:41]), .readInN(rnd[49]), .writeInN(rnd[50]), .holdAckInN(rnd[51]),
		.busClockIn(rnd[52]), .latchEnableIn(rnd[53]), .clockOutSrc(rnd[54]),
		.crystalVcoEnable(rnd[55]), .pageDataVcoEnable(rnd[56]),
		.programmeDeliveryVcoEnable(rnd[57]));

	assign regs = '{clockControl0, clockControl1, peripheralClock, powerMode0, powerMode1,
		powerMode2, writeProtect, portDirection, serialAControl, serialBControl};

	// ----
	// Clock, stimulus and timeout
	// ----
	always #10 clk = ~clk;
	always @(negedge clk) begin
		rnd = {$random(seed), $random(seed)};
		subTick <= (cycles[1:0] == 2'h0);
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_count++;
			give_verdict();
		end
	end

	// ----
	// Tasks
	// ----
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chkRegs();
		for (int j = 0; j < 10; j++) cmp(regs[j], j == 6 ? mp : m[j]);
	endtask
	task wr(input int sel, input int dat);
		int ok;
		@(negedge clk);
		chkRegs();
		wrSel = sel[3:0];
		wrData = dat[7:0];
		wrEn = 1;
		if (sel == 6) mp = dat & 7;
		else begin
			ok = (sel < 3) ? mp & 1 : (sel < 6) ? mp & 2 : (sel < 10) ? mp & 4 : 0;
			if (ok != 0 && m[5][1] && sel < 2) m[sel] = sel == 0 ?
				(m[0] & 8'ha4) | (dat & 8'h5b) : (m[1] & 8'h03) | (dat & 8'hfc);
			else if (ok != 0) m[sel] = dat;
			if (sel == 1 && ok != 0 && m[1][0]) begin
				m[1] |= 8'h20;
				m[0] |= 8'h40;
			end
			mp &= 3;
		end
	endtask
	task idle();
		@(negedge clk);
		chkRegs();
		wrEn = 0;
	endtask
	task give_verdict();
		if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		mp = 0;
		m = '{default: 0};
		repeat (12) @(negedge clk);
		resetn = 1;
		for (i = 0; i < 300; i++) begin
			s = $random(seed) & 15;
			d = $random(seed) & 255;
			if (s > 10) s = 6;
			if (s == 1) d &= 8'hfe;
			wr(s, d);
		end
		wr(6, 3);
		wr(0, 0);
		wr(5, 2);
		wr(6, 1);
		wr(0, 8'hff);
		wr(1, 8'h03);
		wr(6, 4);
		wr(7, 8'h5a);
		wr(8, 8'h33);
		for (k = 0; k < 3; k++) begin
			singleChipMode = (k != 2);
			clockOutSel = k + 1;
			wr(6, 3);
			wr(5, 0);
			wr(0, k == 0 ? 8'h80 : 8'h00);
			wr(1, 1);
			idle();
			cmp(stopped, 1);
			a = busAddr[7:0];
			p = ioPort;
			c = clockOutputPin;
			d = {chipSelectN, byteHighEnableOutputN, busData[2:0]};
			wakeIrqReq = '1;
			globalIrqEnable = 1;
			repeat (3) @(negedge clk);
			cmp(stopped, 1);
			cmp(busAddr[7:0], a);
			cmp(ioPort, p);
			cmp({chipSelectN, byteHighEnableOutputN, busData[2:0]}, d);
			if (k == 2) cmp({readN, writeN, holdAcknowledgeOutputN, busClock, latchEnable}, 31);
			else cmp(clockOutputPin, k == 0 ? 1 : c);
			if (k == 2) begin
				resetn = 0;
				@(negedge clk);
				resetn = 1;
				mp = 0;
				m = '{default: 0};
				cmp(stopped, 0);
			end else begin
				if (k == 0) nmiN = 0;
				else irqPriorityLevel[5:3] = 3'h2;
				for (n = 0; n < 10 && irqServiceStart !== 1'b1; n++) @(negedge clk);
				cmp(irqServiceStart, 1);
				cmp(wakeByNmi, k == 0);
				m[1] &= 8'hfe;
				nmiN = 1;
				wakeIrqReq = '0;
				irqPriorityLevel = '0;
				t = 0;
				repeat (16) begin
					@(negedge clk);
					t += (cpuTick === 1'b1);
				end
				cmp(t, k == 0 ? 4 : 2);
			end
			globalIrqEnable = 0;
		end
		idle();
		give_verdict();
	end
endmodule // tb_stop_mode_clock_protect

`default_nettype wire
